// File: dbvc_pkg.sv
// Purpose: shared constants for the dual step-down converter control bank
// Assumes: byte-wide registers, voltages carried as 12-bit millivolt values
// Notes:   field positions are fixed here and used by the register bank and the bench; the ramp takes only the step timing
package dbvc_pkg;
  localparam logic [6:0]  CHIP_ADDR      = 7'h36;  // serial chip address
  localparam logic [7:0]  IDX_CTRL       = 8'h00;  // converter_control
  localparam logic [7:0]  IDX_SET1       = 8'h01;  // first_converter_setting
  localparam logic [7:0]  IDX_SET2       = 8'h02;  // second_converter_setting
  // converter_control fields
  localparam int          CTRL_SS_EN     = 0;      // spread spectrum enable
  localparam int          CTRL_SS_FMOD   = 1;      // 1: 1 kHz, 0: 2 kHz
  localparam int          CTRL_MSTEP     = 2;      // micro-stepping enable
  localparam logic [7:0]  CTRL_MASK      = 8'h07;  // implemented bits
  localparam logic [7:0]  CTRL_RST       = 8'h02;  // modulation rate 1 kHz
  // converter setting fields
  localparam int          CODE_W         = 5;      // voltage code width
  localparam int          SET_FPWM       = 5;      // forced pwm select
  localparam int          SET2_PORDIS    = 6;      // power-on-reset disable
  localparam logic [7:0]  SET1_MASK      = 8'h3f;  // bits 6 and 7 unused
  localparam logic [7:0]  SET2_MASK      = 8'h7f;  // bit 7 unused
  // voltage code map, millivolts
  localparam logic [4:0]  C1_MIN         = 5'h05;  // 1.00 V
  localparam logic [4:0]  C1_MAX         = 5'h19;  // 2.00 V
  localparam logic [11:0] C1_BASE_MV     = 12'h3e8; // 1000 mV
  localparam logic [11:0] C1_STEP_MV     = 12'h032; // 50 mV
  localparam logic [4:0]  C2_LOW         = 5'h01;  // 1.8 V
  localparam logic [4:0]  C2_TRIM        = 5'h02;  // factory trimmed level
  localparam logic [4:0]  C2_MIN         = 5'h03;  // 2.0 V
  localparam logic [4:0]  C2_MAX         = 5'h10;  // 3.3 V
  localparam logic [11:0] C2_LOW_MV      = 12'h708; // 1800 mV
  localparam logic [11:0] C2_BASE_MV     = 12'h7d0; // 2000 mV
  localparam logic [11:0] C2_STEP_MV     = 12'h064; // 100 mV
  // micro-step timing
  localparam int          STEP_TIME_US   = 32;     // hold per step
  localparam int          CLK_MHZ        = 200;    // sys_clk rate
  localparam int          STEP_CYC       = STEP_TIME_US * CLK_MHZ;
endpackage : dbvc_pkg

// File: dbvc_ramp_if.sv
// Purpose: carrier between the register bank and one ramp stepper
// Assumes: one instance per converter
// Notes:   ctrl side owns target and step size, ramp side owns the level
`timescale 1ns/1ps
`default_nettype none
interface dbvc_ramp_if;
  logic [11:0] target_mv;  // decoded target
  logic [11:0] step_mv;    // size of one micro-step
  logic        mstep_en;   // micro-stepping on
  logic [11:0] level_mv;   // present regulated level
  logic        busy;       // level differs from target
  modport ctrl (output target_mv, output step_mv, output mstep_en,
                input level_mv, input busy);
  modport ramp (input target_mv, input step_mv, input mstep_en,
                output level_mv, output busy);
endinterface : dbvc_ramp_if
`default_nettype wire

// File: dbvc_ramp.sv
// Purpose: walks one converter level toward its target in fixed steps
// Assumes: target changes only on register writes
// Notes:   the hold counter restarts at every step, so each level lasts a full period
`timescale 1ns/1ps
`default_nettype none
module dbvc_ramp #(
  parameter int          STEP_CYCLES = dbvc_pkg::STEP_CYC,  // cycles per step
  parameter logic [11:0] RST_MV      = 12'h000              // level after reset
) (
  input  wire logic  sys_clk,
  input  wire logic  nrst,
  dbvc_ramp_if.ramp  rif
);
  logic [12:0] hold_r;   // step hold counter
  logic [11:0] level_r;  // present level
  logic [11:0] gap;      // distance to target
  logic        up;       // target above level
  logic        at_end;   // hold period over

  // distance is taken in the right direction to avoid underflow
  assign up     = rif.target_mv > level_r;
  assign gap    = up ? (rif.target_mv - level_r) : (level_r - rif.target_mv);
  assign at_end = hold_r == 13'(STEP_CYCLES - 1);

  // hold counter runs only while a ramp is pending
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      hold_r <= 13'h0000;
    else if (!rif.mstep_en || level_r == rif.target_mv || at_end)
      hold_r <= 13'h0000;  // idle or step taken
    else
      hold_r <= hold_r + 13'h0001;
  end

  // level update: direct jump or one step per hold period
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      level_r <= RST_MV;
    else if (!rif.mstep_en)
      level_r <= rif.target_mv;  // no ramp when micro-stepping is off
    else if (level_r != rif.target_mv && at_end)
    begin
      // a late target change simply redirects the next step
      if (gap <= rif.step_mv)
        level_r <= rif.target_mv;  // last partial step snaps
      else if (up)
        level_r <= level_r + rif.step_mv;
      else
        level_r <= level_r - rif.step_mv;
    end
  end

  assign rif.level_mv = level_r;
  assign rif.busy     = level_r != rif.target_mv;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // a move only counts as a step if stepping was on when it was made
  sequence s_step_taken;
    $past(rif.mstep_en) && rif.mstep_en && $changed(level_r);
  endsequence
  sequence s_level_held;
    $stable(level_r) [*8];
  endsequence

  a_direct_jump: assert property (!rif.mstep_en |=> level_r == $past(rif.target_mv))
    else $error("level did not follow target with stepping off");
  a_step_size: assert property (s_step_taken |->
      (($past(gap) > $past(rif.step_mv)) ? (level_r == $past(level_r) + $past(rif.step_mv)
       || level_r == $past(level_r) - $past(rif.step_mv)) : level_r == $past(rif.target_mv)))
    else $error("micro-step size wrong");
  a_step_hold: assert property (s_step_taken ##1 rif.mstep_en |-> s_level_held)
    else $error("micro-step level not held");
  a_hold_bound: assert property (hold_r < 13'(STEP_CYCLES))
    else $error("hold counter ran past the step period");
endmodule : dbvc_ramp
`default_nettype wire

// File: dbvc_regs.sv
// Purpose: control bank of a dual step-down regulator behind a serial slave
// Assumes: the serial slave delivers each decoded transfer as a one-cycle request
// Notes:   invalid voltage codes are stored but leave the target unchanged
// Operation
// - control register at index 00
// - first converter code and mode at 01
// - second converter code, mode, reset-disable at 02
// - first converter 1.00-2.00 V, 50 mV codes
// - second converter 1.8, 2.0-3.3 V codes
// - second converter code 00010 gives trimmed level
// - voltage registers reset to trimmed defaults
// - micro-stepping ramps instead of jumping
// - first converter 50 mV steps, 32 us each
// - second converter 100 mV steps, 32 us each
// - write: chip, index, data stored in register
// - device answers only chip address 36h
// - mode bit forces continuous pwm
// - modulation rate bit: 1 kHz set, default
`timescale 1ns/1ps
`default_nettype none
module dbvc_regs #(
  parameter int          STEP_CYCLES = dbvc_pkg::STEP_CYC,  // cycles per step
  parameter logic [4:0]  DEF_CODE1   = 5'h09,     // trimmed default, 1.2 V
  parameter logic [4:0]  DEF_CODE2   = 5'h10,     // trimmed default, 3.3 V
  parameter logic [11:0] TRIM2_MV    = 12'h73a    // trimmed code 00010, 1850 mV
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        wr_valid,      // decoded write transfer
  input  wire logic [6:0]  wr_chip,       // chip address of the transfer
  input  wire logic        wr_dir_read,   // direction bit, 0 is write
  input  wire logic [7:0]  wr_index,      // register index byte
  input  wire logic [7:0]  wr_data,       // data byte
  output logic             wr_ack,        // write accepted
  input  wire logic        rd_valid,      // decoded read transfer
  input  wire logic [6:0]  rd_chip,       // chip address of the read
  input  wire logic [7:0]  rd_index,      // register index
  output logic             rd_ack,        // read accepted
  output logic [7:0]       rd_data,       // read byte, registered
  output logic [11:0]      vout1_mv,      // first converter level
  output logic [11:0]      vout2_mv,      // second converter level
  output logic [1:0]       ramp_busy,     // per converter ramp pending
  output logic [1:0]       force_pwm,     // per converter forced pwm
  output logic             ss_en,         // spread spectrum on
  output logic             ss_fmod_1khz,  // modulation 1 kHz, else 2 kHz
  output logic             por2_disable   // second reset output disabled
);
  localparam logic [7:0] SET1_RST = {3'h0, DEF_CODE1};
  localparam logic [7:0] SET2_RST = {3'h0, DEF_CODE2};

  logic [7:0]  ctrl_r;     // converter_control
  logic [7:0]  set1_r;     // first_converter_setting
  logic [7:0]  set2_r;     // second_converter_setting
  logic [11:0] tgt1_r;     // last valid first target
  logic [11:0] tgt2_r;     // last valid second target
  logic [11:0] tgt1_nxt;   // decode of first code
  logic [11:0] tgt2_nxt;   // decode of second code
  logic        ok1;        // first code legal
  logic        ok2;        // second code legal
  logic [4:0]  code1;      // first converter code field
  logic [4:0]  code2;      // second converter code field
  logic [7:0]  rd_nxt;     // read mux
  logic        wr_hit;     // write addressed to us
  logic        rd_hit;     // read addressed to us

  // only our chip address with the write direction is taken
  assign wr_hit = wr_valid && wr_chip == dbvc_pkg::CHIP_ADDR && !wr_dir_read;
  assign rd_hit = rd_valid && rd_chip == dbvc_pkg::CHIP_ADDR;
  assign wr_ack = wr_hit;
  assign rd_ack = rd_hit;

  // register writes, unused bits are never stored so they read zero
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r <= dbvc_pkg::CTRL_RST;
      set1_r <= SET1_RST;
      set2_r <= SET2_RST;
    end
    else if (wr_hit)
    begin
      unique case (wr_index)
        dbvc_pkg::IDX_CTRL: ctrl_r <= wr_data & dbvc_pkg::CTRL_MASK;
        dbvc_pkg::IDX_SET1: set1_r <= wr_data & dbvc_pkg::SET1_MASK;
        dbvc_pkg::IDX_SET2: set2_r <= wr_data & dbvc_pkg::SET2_MASK;
        default: ;  // unmapped index, write dropped
      endcase
    end
  end

  // read mux, unmapped index returns zero
  always_comb
  begin
    rd_nxt = 8'h00;
    unique case (rd_index)
      dbvc_pkg::IDX_CTRL: rd_nxt = ctrl_r;
      dbvc_pkg::IDX_SET1: rd_nxt = set1_r;
      dbvc_pkg::IDX_SET2: rd_nxt = set2_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // read data held until the next accepted read
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rd_data <= 8'h00;
    else if (rd_hit)
      rd_data <= rd_nxt;
  end

  // code decode into millivolts
  assign code1 = set1_r[dbvc_pkg::CODE_W-1:0];
  assign code2 = set2_r[dbvc_pkg::CODE_W-1:0];
  always_comb
  begin
    ok1      = code1 >= dbvc_pkg::C1_MIN && code1 <= dbvc_pkg::C1_MAX;
    tgt1_nxt = dbvc_pkg::C1_BASE_MV
             + 12'(code1 - dbvc_pkg::C1_MIN) * dbvc_pkg::C1_STEP_MV;
    ok2      = code2 >= dbvc_pkg::C2_LOW && code2 <= dbvc_pkg::C2_MAX;
    if (code2 == dbvc_pkg::C2_LOW)
      tgt2_nxt = dbvc_pkg::C2_LOW_MV;
    else if (code2 == dbvc_pkg::C2_TRIM)
      tgt2_nxt = TRIM2_MV;  // one code for both trim variants
    else
      tgt2_nxt = dbvc_pkg::C2_BASE_MV
               + 12'(code2 - dbvc_pkg::C2_MIN) * dbvc_pkg::C2_STEP_MV;
  end

  // targets keep the last legal code so a bad write cannot upset the output
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tgt1_r <= 12'h000;
      tgt2_r <= 12'h000;
    end
    else
    begin
      if (ok1)
        tgt1_r <= tgt1_nxt;
      if (ok2)
        tgt2_r <= tgt2_nxt;
    end
  end

  // one stepper per converter, step size differs per converter
  for (genvar g = 0; g < 2; g++)
  begin : g_conv
    dbvc_ramp_if rif ();
    assign rif.target_mv = (g == 0) ? tgt1_r : tgt2_r;
    assign rif.step_mv   = (g == 0) ? dbvc_pkg::C1_STEP_MV : dbvc_pkg::C2_STEP_MV;
    assign rif.mstep_en  = ctrl_r[dbvc_pkg::CTRL_MSTEP];
    assign ramp_busy[g]  = rif.busy;
    dbvc_ramp #(
      .STEP_CYCLES (STEP_CYCLES),
      .RST_MV      (12'h000)
    ) u_ramp (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .rif     (rif)
    );
  end

  assign vout1_mv     = g_conv[0].rif.level_mv;
  assign vout2_mv     = g_conv[1].rif.level_mv;
  assign force_pwm    = {set2_r[dbvc_pkg::SET_FPWM], set1_r[dbvc_pkg::SET_FPWM]};
  assign ss_en        = ctrl_r[dbvc_pkg::CTRL_SS_EN];
  assign ss_fmod_1khz = ctrl_r[dbvc_pkg::CTRL_SS_FMOD];
  assign por2_disable = set2_r[dbvc_pkg::SET2_PORDIS];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // bank checks: all on the rising edge, all held off while in reset
  // each one looks one edge past the cause, where registered state has settled

  // an accepted write to the first setting lands masked on the next edge
  a_write_first: assert property (wr_hit && wr_index == dbvc_pkg::IDX_SET1 |=>
      set1_r == ($past(wr_data) & dbvc_pkg::SET1_MASK))
    else $error("first setting write not stored");
  // another chip on the shared bus must never reach our registers
  a_chip_filter: assert property (wr_valid && wr_chip != dbvc_pkg::CHIP_ADDR |=>
      $stable(ctrl_r) && $stable(set1_r) && $stable(set2_r))
    else $error("write to foreign chip address stored");
  // the read byte is the control value seen at the accepting edge
  a_read_ctrl: assert property (rd_hit && rd_index == dbvc_pkg::IDX_CTRL |=>
      rd_data == $past(ctrl_r))
    else $error("control register read wrong");
  // legal first codes climb from the base level in 50 mV steps
  a_decode_first: assert property (ok1 |=>
      tgt1_r == dbvc_pkg::C1_BASE_MV
              + 12'($past(code1) - dbvc_pkg::C1_MIN) * dbvc_pkg::C1_STEP_MV)
    else $error("first converter decode wrong");
  // the trimmed code ignores the ladder and takes the trim parameter
  a_decode_trim: assert property (code2 == dbvc_pkg::C2_TRIM |=> tgt2_r == TRIM2_MV)
    else $error("trimmed code decode wrong");
  // an illegal second code must leave the running target alone
  a_bad_code_hold: assert property (!ok2 |=> $stable(tgt2_r))
    else $error("invalid second code changed target");
  // the modulation rate pin follows the written control bit
  a_fmod_map: assert property (wr_hit && wr_index == dbvc_pkg::IDX_CTRL |=>
      ss_fmod_1khz == $past(wr_data[dbvc_pkg::CTRL_SS_FMOD]))
    else $error("modulation rate output wrong");
  // forced pwm of the second converter follows its setting write
  a_fpwm_map: assert property (wr_hit && wr_index == dbvc_pkg::IDX_SET2 |=>
      force_pwm[1] == $past(wr_data[dbvc_pkg::SET_FPWM]))
    else $error("forced pwm not following write");
  // a read for another chip must leave the last answer standing
  a_read_refused: assert property (rd_valid && rd_chip != dbvc_pkg::CHIP_ADDR |=>
      $stable(rd_data))
    else $error("read for foreign chip address changed read data");
  // the read direction bit turns a transfer away from the write path
  a_dir_refused: assert property (wr_valid && wr_dir_read |=>
      $stable(ctrl_r) && $stable(set1_r) && $stable(set2_r))
    else $error("transfer with read direction stored");
  // the lowest second code has its own level below the 100 mV ladder
  a_decode_low: assert property (code2 == dbvc_pkg::C2_LOW |=>
      tgt2_r == dbvc_pkg::C2_LOW_MV)
    else $error("second converter low code decode wrong");
  // second codes from the ladder start upwards climb in 100 mV steps
  a_decode_second: assert property (ok2 && code2 >= dbvc_pkg::C2_MIN |=>
      tgt2_r == dbvc_pkg::C2_BASE_MV
              + 12'($past(code2) - dbvc_pkg::C2_MIN) * dbvc_pkg::C2_STEP_MV)
    else $error("second converter decode wrong");
endmodule : dbvc_regs
`default_nettype wire

// File: dbvc_host_model.sv
// Purpose: behavioural serial master issuing decoded transfers to the bank
// Assumes: one transfer per call, requests launched just after rising edges
// Notes:   idle index and data lines show inverted values so stale bytes never match
`timescale 1ns/1ps
`default_nettype none
module dbvc_host_model (
  input  wire logic       sys_clk,   // bank clock
  input  wire logic       wr_ack,    // write accepted
  input  wire logic       rd_ack,    // read accepted
  output logic            wr_valid,  // write request
  output logic [6:0]      wr_chip,   // chip address of the write
  output logic            wr_dir_read, // direction bit
  output logic [7:0]      wr_index,  // register index byte
  output logic [7:0]      wr_data,   // data byte
  output logic            rd_valid,  // read request
  output logic [6:0]      rd_chip,   // chip address of the read
  output logic [7:0]      rd_index   // register index of the read
);
  // quiet bus at time zero
  initial
  begin
    {wr_valid, wr_chip, wr_dir_read, wr_index, wr_data} = '0;
    {rd_valid, rd_chip, rd_index} = '0;
  end

  // chip address with direction, then index, then data, held for one sampling edge
  task automatic write_reg(input logic [6:0] chip, input logic dir, input logic [7:0] idx,
                           input logic [7:0] dat, output logic ack);
    @(posedge sys_clk);
    {wr_valid, wr_chip, wr_dir_read, wr_index, wr_data} <= {1'b1, chip, dir, idx, dat};
    @(negedge sys_clk);
    ack = wr_ack;
    @(posedge sys_clk);
    wr_valid <= 1'b0;
    {wr_index, wr_data} <= ~{idx, dat};
  endtask : write_reg

  // one read request, released only after its sampling edge
  task automatic read_reg(input logic [6:0] chip, input logic [7:0] idx, output logic ack);
    @(posedge sys_clk);
    {rd_valid, rd_chip, rd_index} <= {1'b1, chip, idx};
    @(negedge sys_clk);
    ack = rd_ack;
    @(posedge sys_clk);
    rd_valid <= 1'b0;
    rd_index <= ~idx;
  endtask : read_reg
endmodule : dbvc_host_model
`default_nettype wire

// File: tb_dual_buck_voltage_ctrl_regs.sv
// Purpose: self-checking bench for the dual converter control bank
// Assumes: shortened step hold, decoded transfers from the host model
// Notes:   read data is checked from a queue by a separate monitor process
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_dual_buck_voltage_ctrl_regs;
  localparam int          STEP = 10;       // short hold keeps the run brief
  localparam logic [11:0] TRIM = 12'h76c;  // 1900 mV variant, not the default
  logic        sys_clk, nrst, wr_valid, wr_dir_read, wr_ack, rd_valid, rd_ack, ack_v, rd_seen;
  logic        ss_en, ss_fmod_1khz, por2_disable;
  logic [6:0]  wr_chip, rd_chip;
  logic [7:0]  wr_index, wr_data, rd_index, rd_data, s1, s2, d, rd_exp;
  logic [11:0] vout1_mv, vout2_mv, m1, m2;  // m1/m2: expected levels
  logic [1:0]  ramp_busy, force_pwm;
  logic [7:0]  exp_q[$];                    // expected read bytes, oldest first
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          c;

  // 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  dbvc_regs #(.STEP_CYCLES(STEP), .DEF_CODE1(5'h09), .DEF_CODE2(5'h10), .TRIM2_MV(TRIM)) dut (
    .sys_clk, .nrst, .wr_valid, .wr_chip, .wr_dir_read, .wr_index, .wr_data, .wr_ack,
    .rd_valid, .rd_chip, .rd_index, .rd_ack, .rd_data, .vout1_mv, .vout2_mv, .ramp_busy,
    .force_pwm, .ss_en, .ss_fmod_1khz, .por2_disable);
  dbvc_host_model host (.sys_clk, .wr_ack, .rd_ack, .wr_valid, .wr_chip, .wr_dir_read,
    .wr_index, .wr_data, .rd_valid, .rd_chip, .rd_index);

  // illegal codes leave the previous level standing
  function automatic logic [11:0] dec1(input logic [4:0] k, input logic [11:0] p);
    if (k >= dbvc_pkg::C1_MIN && k <= dbvc_pkg::C1_MAX)
      return dbvc_pkg::C1_BASE_MV + 12'(k - dbvc_pkg::C1_MIN) * dbvc_pkg::C1_STEP_MV;
    return p;
  endfunction : dec1

  function automatic logic [11:0] dec2(input logic [4:0] k, input logic [11:0] p);
    if (k == dbvc_pkg::C2_LOW)
      return dbvc_pkg::C2_LOW_MV;
    if (k == dbvc_pkg::C2_TRIM)
      return TRIM;
    if (k >= dbvc_pkg::C2_MIN && k <= dbvc_pkg::C2_MAX)
      return dbvc_pkg::C2_BASE_MV + 12'(k - dbvc_pkg::C2_MIN) * dbvc_pkg::C2_STEP_MV;
    return p;
  endfunction : dec2

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    logic ack;
    host.write_reg(dbvc_pkg::CHIP_ADDR, 1'b0, idx, dat, ack);
    `CHK(ack, 1'b1)
  endtask : wr

  // expected byte is queued before the request so the monitor always finds it
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic ack;
    exp_q.push_back(e);
    host.read_reg(dbvc_pkg::CHIP_ADDR, idx, ack);
    `CHK(ack, 1'b1)
  endtask : rd

  // counts falling edges until the chosen level moves, bounded
  task automatic wait_step(input logic w, output int n);
    logic [11:0] old;
    old = w ? vout2_mv : vout1_mv;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while ((w ? vout2_mv : vout1_mv) === old && n < 200);
  endtask : wait_step

  task automatic complete_run;
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // monitor: rd_data settles one edge after an accepted read
  always @(posedge sys_clk) rd_seen <= nrst & (rd_ack === 1'b1);
  always @(negedge sys_clk)
  begin
    if (rd_seen)
    begin
      rd_exp = exp_q.pop_front();
      `CHK(rd_data, rd_exp)
    end
  end

  // hang guard, far above the expected run of under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  initial
  begin
    nrst = 1'b0;
    d = 8'($urandom(32'h0f5d));
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(vout1_mv, 12'h4b0)
    `CHK(vout2_mv, 12'hce4)
    `CHK(ss_fmod_1khz, 1'b1)
    rd(dbvc_pkg::IDX_CTRL, 8'h02);
    rd(dbvc_pkg::IDX_SET1, 8'h09);
    rd(dbvc_pkg::IDX_SET2, 8'h10);
    m1 = 12'h4b0;
    m2 = 12'hce4;
    // every code on both converters, random mode bits, stepping off
    for (int i = 0; i < 32; i++)
    begin
      s1 = {3'($urandom), 5'(i)};
      s2 = {3'($urandom), 5'(31 - i)};
      wr(dbvc_pkg::IDX_SET1, s1);
      wr(dbvc_pkg::IDX_SET2, s2);
      m1 = dec1(s1[4:0], m1);
      m2 = dec2(s2[4:0], m2);
      repeat (4) @(negedge sys_clk);
      `CHK(vout1_mv, m1)
      `CHK(vout2_mv, m2)
      `CHK(force_pwm, {s2[5], s1[5]})
      `CHK(por2_disable, s2[6])
      rd(dbvc_pkg::IDX_SET1, s1 & dbvc_pkg::SET1_MASK);
      rd(dbvc_pkg::IDX_SET2, s2 & dbvc_pkg::SET2_MASK);
      d = 8'($urandom) & 8'hfb;
      wr(dbvc_pkg::IDX_CTRL, d);
      rd(dbvc_pkg::IDX_CTRL, d & dbvc_pkg::CTRL_MASK);
      `CHK({ss_fmod_1khz, ss_en}, d[1:0])
    end
    // refused and unmapped transfers
    host.write_reg(7'h37, 1'b0, dbvc_pkg::IDX_SET1, 8'h0c, ack_v);
    `CHK(ack_v, 1'b0)
    host.write_reg(dbvc_pkg::CHIP_ADDR, 1'b1, dbvc_pkg::IDX_SET1, 8'h0c, ack_v);
    `CHK(ack_v, 1'b0)
    rd(dbvc_pkg::IDX_SET1, s1 & dbvc_pkg::SET1_MASK);
    wr(8'h03, 8'h55);
    rd(8'h03, 8'h00);
    host.read_reg(7'h35, dbvc_pkg::IDX_SET1, ack_v);
    `CHK(ack_v, 1'b0)
    `CHK(rd_data, 8'h00)
    // micro-stepping: 1000 -> 1100 mV, then a redirect mid-ramp
    wr(dbvc_pkg::IDX_SET1, 8'h05);
    wr(dbvc_pkg::IDX_SET2, 8'h10);
    repeat (4) @(negedge sys_clk);
    wr(dbvc_pkg::IDX_CTRL, 8'h04);
    wr(dbvc_pkg::IDX_SET1, 8'h07);
    wait_step(1'b0, c);
    `CHK(vout1_mv, 12'h41a)
    `CHK(ramp_busy[0], 1'b1)
    wait_step(1'b0, c);
    `CHK(vout1_mv, 12'h44c)
    `CHK(c, STEP)
    wr(dbvc_pkg::IDX_SET1, 8'h0b);
    wait_step(1'b0, c);
    `CHK(vout1_mv, 12'h47e)
    wr(dbvc_pkg::IDX_SET1, 8'h05);
    wait_step(1'b0, c);
    `CHK(vout1_mv, 12'h44c)
    wait_step(1'b0, c);
    `CHK(vout1_mv, 12'h41a)
    // second converter steps down 3300 -> 3100 mV
    wr(dbvc_pkg::IDX_SET2, 8'h0e);
    wait_step(1'b1, c);
    `CHK(vout2_mv, 12'hc80)
    wait_step(1'b1, c);
    `CHK(vout2_mv, 12'hc1c)
    `CHK(c, STEP)
    `CHK(ramp_busy, 2'b00)
    complete_run();
  end
endmodule : tb_dual_buck_voltage_ctrl_regs
`default_nettype wire
